// ==== msc_pkg.sv ====
// constants shared by the module end and the host end of the sideband link
// assumes a 200 MHz system clock on both ends
package msc_pkg;
   // ----------------------------------------
   // two-wire addressing and module memory map
   // ----------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [7:0] MM_ID = 8'h00;
   localparam logic [7:0] MM_STATUS = 8'h01;
   localparam logic [7:0] MM_FLAGS = 8'h02;
   localparam logic [7:0] MM_MASK = 8'h03;
   localparam logic [7:0] MM_CTRL = 8'h04;
   localparam int ST_NOT_READY = 0;
   localparam int ST_LOW_POWER = 1;
   localparam int ST_FAULT = 2;
   localparam int FL_RESET_DONE = 0;
   localparam int FL_FAULT = 1;
   localparam int CTRL_HIGH_POWER = 0;
   localparam logic [7:0] MASK_RST = 8'h03;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int RST_MIN_NS = 100;
   localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int INIT_TIME_MS = 2000;
   localparam int INIT_CYC = INIT_TIME_MS * CLK_MHZ * 1000;
   localparam int SCL_PERIOD_NS = 80;
   localparam int QTR_CYC = SCL_PERIOD_NS * CLK_MHZ / 1000 / 4;
   // ----------------------------------------
   // host controller registers
   // ----------------------------------------
   localparam logic [7:0] H_CTRL = 8'h00;
   localparam logic [7:0] H_XFER = 8'h04;
   localparam logic [7:0] H_RESULT = 8'h08;
   localparam logic [7:0] H_IRQ_STAT = 8'h0c;
   localparam logic [7:0] H_IRQ_CLR = 8'h10;
   localparam logic [7:0] H_IRQ_EN = 8'h14;
   localparam int HC_RESET = 0;
   localparam int HC_LOWPWR = 1;
   localparam int HX_READ = 16;
   localparam int HR_BUSY = 8;
   localparam int HR_NACK = 9;
   localparam int HR_INT = 10;
   localparam int HR_PRES = 11;
   localparam int IRQ_W = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_NACK = 1;
   localparam int IRQ_MOD = 2;
   localparam int IRQ_PRES = 3;
endpackage

// ==== msc_sideband_if.sv ====
// sideband pins between one module and its host board controller
// open-drain wires resolve here: a line is low while any enable pulls it
`timescale 1ns/100ps
interface msc_sideband_if;
   logic module_select_n;
   logic module_reset_n;
   logic low_power_request;
   logic scl_h_o;
   logic scl_h_oe;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic int_d_oe;
   logic pres_d_oe;
   logic scl;
   logic sda;
   logic interrupt_n;
   logic module_present_n;
   assign scl = scl_h_oe ? scl_h_o : 1'b1;
   assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
   assign interrupt_n = ~int_d_oe;
   assign module_present_n = ~pres_d_oe;
   modport dev (input module_select_n, module_reset_n, low_power_request, scl, sda,
      output sda_d_o, sda_d_oe, int_d_oe, pres_d_oe);
   modport host (output module_select_n, module_reset_n, low_power_request,
      scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, input scl, sda, interrupt_n, module_present_n);
endinterface

// ==== msc_module_end.sv ====
// module end of the sideband link: two-wire slave, memory map, reset and interrupt
// assumes all link pins are asynchronous to clk_i; nrst_i is the power-up reset
//
// How it works
// [R1] seven pins: select, clock, data, reset, power, present, interrupt
// [R2] serial answers only while select is held low
// [R3] host gives each module its own select line
// [R4] memory map reached over serial clock and data
// [R5] long reset pulse restores every default setting
// [R6] host ignores status until reset-done interrupt
// [R7] reset done: interrupt with not-ready flag cleared
// [R8] power-up also posts the reset-done interrupt
// [R9] low-power request caps allowed power
// [R10] present line pulled low while inserted
// [R11] interrupt pulled low for faults or critical status
// [R12] host reads memory map to find interrupt cause
// [R13] interrupt is open-collector, host supplies pull-up
// [R14] reset pin low-time filtered by counter
// [R15] reading a flag releases it, others keep interrupt
`timescale 1ns/100ps
module msc_module_end #(
   parameter logic [7:0] ID_CODE = 8'h5a, // arbitrary identity value
   parameter int RST_MIN_CYCLES = msc_pkg::RST_MIN_CYC,
   parameter int INIT_CYCLES = msc_pkg::INIT_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   msc_sideband_if.dev link,
   input wire logic fault_i,
   output logic high_power_en_o,
   output logic full_reset_o
);
   import msc_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RLOAD, S_RD, S_RACK
   } msc_slv_t;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [4:0] sy1_reg;
   logic [4:0] sy2_reg;
   logic sel_n;
   logic rstp_n;
   logic lp;
   logic scl;
   logic sda;
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sy1_reg <= 5'h1f;
         sy2_reg <= 5'h1f;
      end else begin
         sy1_reg <= {link.module_select_n, link.module_reset_n, link.low_power_request,
            link.scl, link.sda}; // see [R1]
         sy2_reg <= sy1_reg;
      end
   end

   assign {sel_n, rstp_n, lp, scl, sda} = sy2_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl;
         sda_d_reg <= sda;
      end
   end

   assign scl_rise = scl & ~scl_d_reg;
   assign scl_fall = ~scl & scl_d_reg;
   assign start_c = scl & scl_d_reg & sda_d_reg & ~sda;
   assign stop_c = scl & scl_d_reg & ~sda_d_reg & sda;

   // ----------------------------------------
   // reset pin filter and initialisation
   // ----------------------------------------
   logic [15:0] rst_cnt_reg;
   logic in_rst_reg;
   logic [31:0] init_cnt_reg;
   logic not_ready_reg;
   logic ready_pulse;

   // short glitches on the reset pin never reach the logic
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_cnt_reg <= 16'h0000;
         in_rst_reg <= 1'b0;
      end else if (rstp_n) begin
         rst_cnt_reg <= 16'h0000;
         in_rst_reg <= 1'b0;
      end else if (rst_cnt_reg == 16'(RST_MIN_CYCLES - 1)) begin
         in_rst_reg <= 1'b1; // see [R14]
      end else begin
         rst_cnt_reg <= rst_cnt_reg + 16'h0001;
      end
   end

   // power-up runs the same path as a pin reset, so completion is posted both ways
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         init_cnt_reg <= 32'h0;
         not_ready_reg <= 1'b1; // see [R8]
      end else if (in_rst_reg) begin
         init_cnt_reg <= 32'h0;
         not_ready_reg <= 1'b1; // see [R5]
      end else if (not_ready_reg) begin
         if (ready_pulse) begin
            not_ready_reg <= 1'b0;
         end else begin
            init_cnt_reg <= init_cnt_reg + 32'h1;
         end
      end
   end

   assign ready_pulse = not_ready_reg & ~in_rst_reg & (init_cnt_reg == 32'(INIT_CYCLES - 1));

   // ----------------------------------------
   // two-wire slave
   // ----------------------------------------
   msc_slv_t state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic rw_reg;
   logic first_reg;
   logic sda_oe_reg;
   logic slv_go;
   logic [7:0] rd_val;
   logic [7:0] wdata;
   logic mem_we;
   logic rd_load;

   assign slv_go = ~(in_rst_reg | sel_n | stop_c | start_c);
   assign wdata = {shift_reg[6:0], sda};
   assign mem_we = slv_go & (state_reg == S_WR) & scl_rise & (bit_cnt_reg == 3'h7) & ~first_reg;
   assign rd_load = slv_go & (state_reg == S_RLOAD) & scl_fall;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= S_IDLE;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         first_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (in_rst_reg | sel_n | stop_c) begin
         state_reg <= S_IDLE; // see [R2]
         sda_oe_reg <= 1'b0;
      end else if (start_c) begin
         state_reg <= S_ADDR;
         bit_cnt_reg <= 3'h0;
         sda_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            S_ADDR: begin
               if (scl_rise) begin
                  shift_reg <= wdata;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7) begin
                     rw_reg <= sda;
                     state_reg <= (shift_reg[6:0] == DEV_ADDR) ? S_AACK : S_IDLE;
                  end
               end
            end
            S_AACK: begin
               if (scl_fall) begin
                  sda_oe_reg <= 1'b1;
               end else if (scl_rise) begin
                  state_reg <= rw_reg ? S_RLOAD : S_WR; // see [R4]
                  bit_cnt_reg <= 3'h0;
                  first_reg <= 1'b1;
               end
            end
            S_WR: begin
               if (scl_fall) begin
                  sda_oe_reg <= 1'b0;
               end else if (scl_rise) begin
                  shift_reg <= wdata;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7) begin
                     state_reg <= S_WACK;
                     first_reg <= 1'b0;
                     ptr_reg <= first_reg ? wdata : ptr_reg + 8'h01;
                  end
               end
            end
            S_WACK: begin
               if (scl_fall) begin
                  sda_oe_reg <= 1'b1;
               end else if (scl_rise) begin
                  state_reg <= S_WR;
                  bit_cnt_reg <= 3'h0;
               end
            end
            S_RLOAD: begin
               if (scl_fall) begin
                  shift_reg <= rd_val;
                  sda_oe_reg <= ~rd_val[7];
                  ptr_reg <= ptr_reg + 8'h01;
                  bit_cnt_reg <= 3'h0;
                  state_reg <= S_RD;
               end
            end
            S_RD: begin
               if (scl_fall) begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  sda_oe_reg <= ~shift_reg[6];
               end else if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7) begin
                     state_reg <= S_RACK;
                  end
               end
            end
            S_RACK: begin
               if (scl_fall) begin
                  sda_oe_reg <= 1'b0;
               end else if (scl_rise) begin
                  // a released acknowledge ends the burst
                  state_reg <= sda ? S_IDLE : S_RLOAD;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // memory map
   // ----------------------------------------
   logic [7:0] mask_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] flags_reg;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic fault_d_reg;

   always_comb begin
      rd_val = 8'h00;
      case (ptr_reg)
         MM_ID: rd_val = ID_CODE;
         MM_STATUS: begin
            rd_val[ST_NOT_READY] = not_ready_reg; // see [R7]
            rd_val[ST_LOW_POWER] = lp;
            rd_val[ST_FAULT] = fault_i;
         end
         MM_FLAGS: rd_val = flags_reg;
         MM_MASK: rd_val = mask_reg;
         MM_CTRL: rd_val = ctrl_reg;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_reg <= MASK_RST;
         ctrl_reg <= CTRL_RST;
      end else if (in_rst_reg) begin
         mask_reg <= MASK_RST; // see [R5]
         ctrl_reg <= CTRL_RST;
      end else if (mem_we) begin
         if (ptr_reg == MM_MASK) begin
            mask_reg <= wdata;
         end
         if (ptr_reg == MM_CTRL) begin
            ctrl_reg <= wdata;
         end
      end
   end

   always_comb begin
      flag_set = 8'h00;
      flag_set[FL_RESET_DONE] = ready_pulse; // see [R7]
      flag_set[FL_FAULT] = fault_i & ~fault_d_reg; // see [R11]
      flag_clr = (rd_load && ptr_reg == MM_FLAGS) ? rd_val : 8'h00;
   end

   // only the bits the host has just read are cleared, or all of them during a pin reset; a new event wins
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags_reg <= 8'h00;
         fault_d_reg <= 1'b0;
      end else begin
         fault_d_reg <= fault_i;
         if (in_rst_reg) begin
            flags_reg <= 8'h00;
         end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set; // see [R15]
         end
      end
   end

   // ----------------------------------------
   // pin and user outputs
   // ----------------------------------------
   logic int_oe_reg;
   logic pres_oe_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         int_oe_reg <= 1'b0;
         pres_oe_reg <= 1'b0;
         high_power_en_o <= 1'b0;
         full_reset_o <= 1'b0;
      end else begin
         int_oe_reg <= |(flags_reg & mask_reg); // see [R11]
         pres_oe_reg <= 1'b1; // see [R10]
         high_power_en_o <= ~lp & ctrl_reg[CTRL_HIGH_POWER] & ~not_ready_reg; // see [R9]
         full_reset_o <= in_rst_reg;
      end
   end

   // open-drain: the pin is only ever pulled low, never driven high
   assign link.sda_d_o = 1'b0;
   assign link.sda_d_oe = sda_oe_reg;
   assign link.int_d_oe = int_oe_reg; // see [R13]
   assign link.pres_d_oe = pres_oe_reg;
endmodule

// ==== msc_host_end.sv ====
// host board controller end: register port, two-wire master, sideband pins
// assumes one module per instance, so each module gets its own select line
`timescale 1ns/100ps
module msc_host_end (
   input wire logic clk_i,
   input wire logic nrst_i,
   msc_sideband_if.host link,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [31:0] rdata_o,
   output logic irq_o
);
   import msc_pkg::*;

   typedef enum logic [1:0] {O_START, O_STOP, O_TX, O_RX} msc_op_t;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] sy1_reg;
   logic [2:0] sy2_reg;
   logic [2:0] sy3_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sy1_reg <= 3'h7;
         sy2_reg <= 3'h7;
         sy3_reg <= 3'h7;
      end else begin
         sy1_reg <= {link.sda, link.interrupt_n, link.module_present_n};
         sy2_reg <= sy1_reg;
         sy3_reg <= sy2_reg;
      end
   end

   // ----------------------------------------
   // two-wire master
   // ----------------------------------------
   logic busy_reg;
   logic sel_n_reg;
   logic [2:0] step_reg;
   logic [1:0] q_reg;
   logic [2:0] div_reg;
   logic [3:0] bit_reg;
   logic [7:0] rx_reg;
   logic [7:0] rd_reg;
   logic nack_reg;
   logic [7:0] xaddr_reg;
   logic [7:0] xdata_reg;
   logic xread_reg;
   logic scl_oe_reg;
   logic sda_oe_reg;
   logic tick;
   logic last;
   logic done;
   logic txbit;
   msc_op_t op;
   logic [7:0] txbyte;

   assign tick = busy_reg & (div_reg == 3'(QTR_CYC - 1));

   // a read sets the pointer, stops, then reads one byte under a fresh start
   always_comb begin
      op = O_STOP;
      txbyte = 8'hff;
      last = 1'b0;
      case ({xread_reg, step_reg})
         4'h0, 4'h8, 4'hc: op = O_START;
         4'h1, 4'h9: begin
            op = O_TX;
            txbyte = {DEV_ADDR, 1'b0};
         end
         4'h2, 4'ha: begin
            op = O_TX;
            txbyte = xaddr_reg;
         end
         4'h3: begin
            op = O_TX;
            txbyte = xdata_reg;
         end
         4'hd: begin
            op = O_TX;
            txbyte = {DEV_ADDR, 1'b1};
         end
         4'he: op = O_RX;
         4'h4, 4'hf: last = 1'b1;
         default: op = O_STOP;
      endcase
   end

   assign txbit = (op == O_TX && bit_reg < 4'h8) ? txbyte[3'h7 - bit_reg[2:0]] : 1'b1;
   assign done = tick & (q_reg == 2'h3) & last;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_reg <= 1'b0;
         sel_n_reg <= 1'b1;
         step_reg <= 3'h0;
         q_reg <= 2'h0;
         div_reg <= 3'h0;
         bit_reg <= 4'h0;
         rx_reg <= 8'h00;
         rd_reg <= 8'h00;
         nack_reg <= 1'b0;
         xaddr_reg <= 8'h00;
         xdata_reg <= 8'h00;
         xread_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (!busy_reg) begin
         if (we_i && addr_i == H_XFER) begin
            busy_reg <= 1'b1;
            sel_n_reg <= 1'b0; // see [R2]
            step_reg <= 3'h0;
            q_reg <= 2'h0;
            div_reg <= 3'h0;
            bit_reg <= 4'h0;
            nack_reg <= 1'b0;
            xaddr_reg <= wdata_i[7:0];
            xdata_reg <= wdata_i[15:8];
            xread_reg <= wdata_i[HX_READ];
         end
      end else begin
         div_reg <= tick ? 3'h0 : div_reg + 3'h1;
         if (tick) begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
               2'h0: scl_oe_reg <= 1'b1;
               2'h1: sda_oe_reg <= (op == O_STOP) | ~((op == O_START) | txbit); // see [R4]
               2'h2: scl_oe_reg <= 1'b0;
               default: begin
                  if (op == O_START || op == O_STOP) begin
                     sda_oe_reg <= (op == O_START);
                     step_reg <= step_reg + 3'h1;
                  end else begin
                     if (bit_reg < 4'h8) begin
                        rx_reg <= {rx_reg[6:0], sy2_reg[2]};
                     end else if (op == O_TX && sy2_reg[2]) begin
                        nack_reg <= 1'b1;
                     end
                     bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
                     if (bit_reg == 4'h8) begin
                        step_reg <= step_reg + 3'h1;
                     end
                  end
                  if (last) begin
                     busy_reg <= 1'b0;
                     sel_n_reg <= 1'b1;
                     rd_reg <= rx_reg;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // registers and interrupt
   // ----------------------------------------
   logic rst_n_reg;
   logic lp_reg;
   logic [IRQ_W-1:0] stat_reg;
   logic [IRQ_W-1:0] en_reg;
   logic [IRQ_W-1:0] set_c;
   logic [IRQ_W-1:0] clr_c;

   always_comb begin
      set_c = '0;
      set_c[IRQ_DONE] = done;
      set_c[IRQ_NACK] = done & nack_reg;
      set_c[IRQ_MOD] = sy3_reg[1] & ~sy2_reg[1]; // see [R12]
      set_c[IRQ_PRES] = sy3_reg[0] ^ sy2_reg[0];
      clr_c = (we_i && addr_i == H_IRQ_CLR) ? wdata_i[IRQ_W-1:0] : '0;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_n_reg <= 1'b1;
         lp_reg <= 1'b1;
         stat_reg <= '0;
         en_reg <= '0;
         irq_o <= 1'b0;
      end else begin
         if (we_i && addr_i == H_CTRL) begin
            rst_n_reg <= ~wdata_i[HC_RESET];
            lp_reg <= wdata_i[HC_LOWPWR];
         end
         if (we_i && addr_i == H_IRQ_EN) begin
            en_reg <= wdata_i[IRQ_W-1:0];
         end
         stat_reg <= (stat_reg & ~clr_c) | set_c;
         irq_o <= |(stat_reg & en_reg);
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h0;
      end else if (re_i) begin
         case (addr_i)
            H_CTRL: rdata_o <= {30'h0, lp_reg, ~rst_n_reg};
            H_RESULT: rdata_o <= {20'h0, ~sy2_reg[0], ~sy2_reg[1], nack_reg, busy_reg, rd_reg};
            H_IRQ_STAT: rdata_o <= {28'h0, stat_reg};
            H_IRQ_EN: rdata_o <= {28'h0, en_reg};
            default: rdata_o <= 32'h0;
         endcase
      end else begin
         rdata_o <= 32'h0;
      end
   end

   assign link.module_select_n = sel_n_reg; // see [R3]
   assign link.module_reset_n = rst_n_reg;
   assign link.low_power_request = lp_reg;
   assign link.scl_h_o = 1'b0;
   assign link.scl_h_oe = scl_oe_reg;
   assign link.sda_h_o = 1'b0;
   assign link.sda_h_oe = sda_oe_reg;
endmodule

// ==== msc_sideband_assertions.sv ====
// checker on the sideband wires between the module end and the host end
// assumes clk_i clocks both ends and nrst_i is their common power-up reset
`timescale 1ns/100ps
module msc_sideband_assertions #(
   parameter int RST_MIN_CYCLES = 4,
   parameter int INIT_CYCLES = 50
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic scl,
   input wire logic sda_d_o,
   input wire logic sda_d_oe,
   input wire logic int_d_oe,
   input wire logic pres_d_oe
);
   logic [31:0] low_reg;
   logic [31:0] up_reg;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) low_reg <= 32'h0;
      else low_reg <= module_reset_n ? 32'h0 : low_reg + 32'h1;
   end
   // only from power-up: pin resets add a sync lag of their own
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) up_reg <= 32'h0;
      else up_reg <= up_reg + 32'h1;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_sel; module_select_n [*4] |-> !sda_d_oe; endproperty
   a_sel: assert property (p_sel) else $error("data pulled while deselected");
   property p_od; sda_d_oe |-> !sda_d_o; endproperty
   a_od: assert property (p_od) else $error("data driven high");
   property p_scl; $changed(sda_d_oe) |-> !scl || !module_reset_n; endproperty
   a_scl: assert property (p_scl) else $error("data moved with clock high");
   property p_rst; low_reg > RST_MIN_CYCLES + 6 |-> !int_d_oe && !sda_d_oe; endproperty
   a_rst: assert property (p_rst) else $error("pins kept in reset");
   property p_pwr; up_reg < INIT_CYCLES - 1 |-> !int_d_oe; endproperty
   a_pwr: assert property (p_pwr) else $error("interrupt before init");
   property p_rel; $fell(int_d_oe) |-> !module_select_n || !module_reset_n; endproperty
   a_rel: assert property (p_rel) else $error("interrupt dropped unread");
   property p_prs; $past(nrst_i) |-> pres_d_oe; endproperty
   a_prs: assert property (p_prs) else $error("present not pulled");
   property p_rise; $rose(int_d_oe) |-> module_reset_n; endproperty
   a_rise: assert property (p_rise) else $error("interrupt in reset");
   c_int: cover property ($fell(int_d_oe));
   c_rst: cover property (low_reg == RST_MIN_CYCLES + 7);
   c_ack: cover property ($rose(sda_d_oe));
endmodule

// ==== module_sideband_control_test.sv ====
// self-checking bench: host end talks to module end over the sideband wires
// assumes both ends share clk_i; the link clock comes from the host divider
`timescale 1ns/100ps
module module_sideband_control_test;
   import msc_pkg::*;
   localparam int RMIN = 4;
   localparam int INIT = 50;
   localparam logic [7:0] ID = 8'h3c; // arbitrary value
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] addr_i = 8'h0;
   logic [31:0] wdata_i = 32'h0;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic fault_i = 1'b0;
   logic [31:0] rdata_o;
   logic irq_o;
   logic hp;
   logic fr;
   logic [31:0] q;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int mm [8];
   msc_sideband_if link();
   msc_module_end #(.ID_CODE(ID), .RST_MIN_CYCLES(RMIN), .INIT_CYCLES(INIT))
      msc_module_end_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
      .fault_i(fault_i), .high_power_en_o(hp), .full_reset_o(fr));
   msc_host_end msc_host_end_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
      .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
      .rdata_o(rdata_o), .irq_o(irq_o));
   msc_sideband_assertions #(.RST_MIN_CYCLES(RMIN), .INIT_CYCLES(INIT)) chk_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .module_select_n(link.module_select_n),
      .module_reset_n(link.module_reset_n), .scl(link.scl), .sda_d_o(link.sda_d_o),
      .sda_d_oe(link.sda_d_oe), .int_d_oe(link.int_d_oe), .pres_d_oe(link.pres_d_oe));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 40000) begin
         err_count++;
         summarize();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic summarize();
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      @(negedge clk_i);
      q = rdata_o;
   endtask
   // busy is polled at most 1000 times, so a hung engine fails the busy check
   task automatic xf(input logic [7:0] a, input logic [7:0] d, input logic r);
      wr(H_XFER, {15'h0, r, d, a});
      for (int i = 0; i < 1000; i++) begin
         rd(H_RESULT);
         if (q[HR_BUSY] === 1'b0) break;
      end
      chk("busy", 32'h0, 32'(q[HR_BUSY]));
      chk("nack", 32'h0, 32'(q[HR_NACK]));
   endtask
   task automatic rx(input logic [7:0] a, input int e);
      xf(a, 8'h0, 1'b1);
      chk("memory byte", 32'(e), 32'(q[7:0]));
   endtask
   task automatic ri(input int b, input logic e);
      rd(H_RESULT);
      chk("result bit", 32'(e), 32'(q[b]));
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h13ea9d91));
      mm[MM_ID] = ID;
      mm[MM_MASK] = MASK_RST;
      mm[MM_CTRL] = 1;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      w(INIT + 20);
      ri(HR_INT, 1'b1);
      ri(HR_PRES, 1'b1);
      rx(MM_STATUS, 1 << ST_LOW_POWER);
      rx(MM_FLAGS, 1 << FL_RESET_DONE);
      ri(HR_INT, 1'b0);
      rx(MM_ID, mm[MM_ID]);
      xf(MM_CTRL, 8'h1, 1'b0);
      wr(H_CTRL, 32'h0);
      w(6);
      chk("high power", 32'h1, 32'(hp));
      wr(H_CTRL, 32'h2);
      w(6);
      chk("high power", 32'h0, 32'(hp));
      wr(H_IRQ_EN, 32'h1);
      w(3);
      chk("irq", 32'h1, 32'(irq_o));
      wr(H_IRQ_EN, 32'h0);
      w(3);
      chk("irq", 32'h0, 32'(irq_o));
      wr(H_IRQ_EN, 32'h1);
      wr(H_IRQ_CLR, 32'h1);
      w(3);
      chk("irq", 32'h0, 32'(irq_o));
      @(posedge clk_i);
      fault_i <= 1'b1;
      w(4);
      ri(HR_INT, 1'b1);
      rx(MM_FLAGS, 1 << FL_FAULT);
      @(posedge clk_i);
      fault_i <= 1'b0;
      mm[MM_MASK] = $urandom % 256;
      xf(MM_MASK, 8'(mm[MM_MASK]), 1'b0);
      rx(MM_MASK, mm[MM_MASK]);
      wr(H_CTRL, 32'h3);
      wr(H_CTRL, 32'h2);
      w(RMIN + 4);
      rx(MM_CTRL, mm[MM_CTRL]);
      wr(H_CTRL, 32'h3);
      w(RMIN + 8);
      chk("full reset", 32'h1, 32'(fr));
      wr(H_CTRL, 32'h2);
      w(INIT + 20);
      ri(HR_INT, 1'b1);
      rx(MM_MASK, MASK_RST);
      rx(MM_CTRL, CTRL_RST);
      summarize();
   end
endmodule
